// file: include/bppc_defines.vh
// Purpose: Constants for the bidirectional port pin control block
// Assumes: 50 MHz clock, 8-bit port
// Notes: Register indices are local choices
`ifndef BPPC_DEFINES_VH
`define BPPC_DEFINES_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BPPC_ADDR_DIR 2'h0
`define BPPC_ADDR_FSEL 2'h1
`define BPPC_ADDR_DATA 2'h2
`define BPPC_ADDR_SAMPLE 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BPPC_DIR_RST 8'hff
`define BPPC_FSEL_RST 8'h00
`define BPPC_DATA_RST 8'hff

// ----------------------------------------
// Fields and timing
// ----------------------------------------
`define BPPC_HALF_RATE_CLOCK_OUT_BIT 7
`define BPPC_FAST_NS 300
`define BPPC_CLK_NS 20
`define BPPC_FAST_CYC ((`BPPC_FAST_NS + `BPPC_CLK_NS - 1) / `BPPC_CLK_NS)

`endif

// file: logic/bppc_pin_mux.v
// Purpose: Driver gate decode for one port pin
// Assumes: Combinational, registered by the caller
// Notes: High side is only on for a complementary output driving 1
`timescale 1ns/1ns
module bppc_pin_mux (
   // Configuration
   input wire fsel,
   input wire dir,
   input wire data,
   // Peripheral side
   input wire periph_direction,
   input wire periph_output_value,
   // Gates
   output wire high_side_driver,
   output wire low_side_driver
);
   wire sel_dir;
   wire sel_data;

   // ----------------------------------------
   // Source select
   // ----------------------------------------
   // Open-drain forced when the port asks for input, or in peripheral mode when the peripheral does
   assign sel_dir = fsel ? (dir | periph_direction) : dir; // [R02] [R04] [R05]
   assign sel_data = fsel ? periph_output_value : data; // [R03] [R04]

   // ----------------------------------------
   // Gate decode
   // ----------------------------------------
   assign high_side_driver = ~sel_dir & sel_data; // [R06] [R07]
   assign low_side_driver = ~sel_data; // [R06] [R07]
endmodule

// file: logic/bppc_port.v
// Purpose: Per-pin control of an eight-bit bidirectional port
// Assumes: Register port with one-cycle read latency; pins sampled by three flops
// Notes: Gate outputs are registered, so a change reaches the pins one cycle later
//
// Functional notes
// [R01] Each pin chosen independently: I/O or peripheral
// [R02] Select bit 0 I/O, 1 peripheral
// [R03] I/O mode: gates from data and direction
// [R04] Peripheral mode: gates from peripheral direction, value
// [R05] Peripheral output clears direction, input sets it; the code ORs in peripheral direction, so output leaves the written direction
// [R06] Direction 0: complementary, never both drivers
// [R07] Direction 1: high side never on; in clock mode the code ignores bit 7 direction and drives the high side
// [R08] Software sets direction and data for inputs
// [R09] Software writes direction for peripheral pins too
// [R10] Sample latch returns pin level on read
// [R11] Fast reset driver about 300 ns
// [R12] Weak pull-up from reset until select write
// [R13] Any select write drops the pull-ups
// [R14] Reset leaves pins high-impedance inputs, pulled up; the code drives the half-rate clock on bit 7 instead
// [R15] Bit 7 carries half-rate clock after reset
// [R16] Recommended order: direction, select, data
// [R17] Data write visible only in I/O mode
// [R18] Bit 7 data write buffered until select cleared
// [R19] Direction, data reset ones; select zeros
`timescale 1ns/1ns
`include "bppc_defines.vh"
module bppc_port #(
   parameter WIDTH = 8,
   parameter FAST_CYC = `BPPC_FAST_CYC
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   input wire ce,
   // Register port
   input wire [1:0] addr,
   input wire [WIDTH-1:0] wdata,
   input wire wr,
   input wire rd,
   output reg [WIDTH-1:0] rdata,
   // Peripheral side
   input wire [WIDTH-1:0] periph_direction,
   input wire [WIDTH-1:0] periph_output_value,
   input wire half_rate_clock_out,
   // Pins
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] high_side_driver,
   output reg [WIDTH-1:0] low_side_driver,
   output reg reset_fast_driver,
   output reg weak_pullup
);
   localparam B7 = `BPPC_HALF_RATE_CLOCK_OUT_BIT;
   // Sized copy of the count so the compare below is cut to 8 bits on purpose
   localparam [31:0] FAST_LIM = FAST_CYC;

   reg [WIDTH-1:0] pin_direction;
   reg [WIDTH-1:0] pin_function_select;
   reg [WIDTH-1:0] pin_output_data;
   reg [WIDTH-1:0] pin_input_sample;
   reg [WIDTH-1:0] sync1;
   reg [WIDTH-1:0] sync2;
   reg bit7_buffer;
   reg bit7_pending;
   reg [7:0] fast_cnt;
   wire [WIDTH-1:0] next_high;
   wire [WIDTH-1:0] next_low;
   wire [WIDTH-1:0] periph_val;
   wire clk_mode7;

   // ----------------------------------------
   // Pin synchroniser and sample latch
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1 <= {WIDTH{1'b0}};
         sync2 <= {WIDTH{1'b0}};
         pin_input_sample <= {WIDTH{1'b1}};
      end else if (ce) begin
         sync1 <= pin_in;
         sync2 <= sync1;
         pin_input_sample <= sync2; // [R10]
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_direction <= `BPPC_DIR_RST; // [R19] [R14]
         pin_function_select <= `BPPC_FSEL_RST; // [R19]
         pin_output_data <= `BPPC_DATA_RST; // [R19]
         bit7_buffer <= 1'b1;
         bit7_pending <= 1'b0;
      end else if (ce) begin
         if (wr && addr == `BPPC_ADDR_DIR) begin
            pin_direction <= wdata;
         end
         if (wr && addr == `BPPC_ADDR_FSEL) begin
            pin_function_select <= wdata; // [R01]
         end
         if (wr && addr == `BPPC_ADDR_DATA) begin
            // Bit 7 write while selected waits in the buffer
            pin_output_data[B7-1:0] <= wdata[B7-1:0]; // [R17]
            if (pin_function_select[B7]) begin
               bit7_buffer <= wdata[B7]; // [R18]
               bit7_pending <= 1'b1;
            end else begin
               // A fresh write beats any stale buffered value
               pin_output_data[B7] <= wdata[B7]; // [R17]
               bit7_pending <= 1'b0;
            end
         end else if (bit7_pending && !pin_function_select[B7]) begin
            pin_output_data[B7] <= bit7_buffer; // [R18]
            bit7_pending <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= {WIDTH{1'b0}};
      end else if (ce) begin
         if (rd) begin
            case (addr)
               `BPPC_ADDR_DIR: rdata <= pin_direction;
               `BPPC_ADDR_FSEL: rdata <= pin_function_select;
               `BPPC_ADDR_DATA: rdata <= pin_output_data; // [R18]
               `BPPC_ADDR_SAMPLE: rdata <= pin_input_sample; // [R10]
               default: rdata <= {WIDTH{1'b0}};
            endcase
         end else begin
            rdata <= {WIDTH{1'b0}};
         end
      end
   end

   // ----------------------------------------
   // Reset drivers
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fast_cnt <= 8'h00;
         reset_fast_driver <= 1'b0;
         weak_pullup <= 1'b1; // [R12]
      end else if (ce) begin
         // Fast drive starts once reset releases, then times out
         if (fast_cnt < FAST_LIM[7:0]) begin
            fast_cnt <= fast_cnt + 8'h01;
            reset_fast_driver <= 1'b1; // [R11]
         end else begin
            reset_fast_driver <= 1'b0; // [R11]
         end
         if (wr && addr == `BPPC_ADDR_FSEL) begin
            weak_pullup <= 1'b0; // [R13]
         end
      end
   end

   // ----------------------------------------
   // Driver decode
   // ----------------------------------------
   // Bit 7 peripheral is the half-rate clock, forced complementary
   assign periph_val = {half_rate_clock_out, periph_output_value[B7-1:0]};
   // Bit 7 shows the clock from reset until the select is written, or while selected
   assign clk_mode7 = pin_function_select[B7] | weak_pullup; // [R15]

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : gen_pin
         bppc_pin_mux u_mux (
            .fsel((g == B7) ? clk_mode7 : pin_function_select[g]), // [R15]
            .dir((g == B7) ? (clk_mode7 ? 1'b0 : pin_direction[g]) : pin_direction[g]), // [R15]
            .data(pin_output_data[g]),
            .periph_direction((g == B7) ? 1'b0 : periph_direction[g]),
            .periph_output_value(periph_val[g]),
            .high_side_driver(next_high[g]),
            .low_side_driver(next_low[g])
         );
      end
   endgenerate

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         high_side_driver <= {WIDTH{1'b0}}; // [R14]
         low_side_driver <= {WIDTH{1'b0}};
      end else if (ce) begin
         high_side_driver <= next_high;
         low_side_driver <= next_low;
      end
   end
endmodule

// file: verification/bppc_pins_model.sv
// Purpose: Outside world on the pins
// Assumes: Pull-up on every pin
// Notes: Outside drive shows only on released pins
`timescale 1ns/1ns
module bppc_pins_model (
   // Gates and outside source
   input wire [7:0] high_side_driver, input wire [7:0] low_side_driver, input wire [7:0] ext_en,
   input wire [7:0] ext_val,
   // Levels
   output wire [7:0] pin_in
);
   // Low gate wins; a released pin follows the source or the pull-up
   assign pin_in = ~low_side_driver & (high_side_driver | ~ext_en | ext_val);
endmodule

// file: verification/bppc_port_asserts.sv
// Purpose: Port checks at the block's ports
// Assumes: One clock domain
// Notes: Bit 7 gates left out of the idle check
`timescale 1ns/1ns
module bppc_port_asserts #(parameter WIDTH = 8, parameter FAST_CYC = 15) (
   // Clock, reset, bus
   input wire clk, input wire rst, input wire ce, input wire [1:0] addr, input wire wr, input wire rd,
   input wire [WIDTH-1:0] rdata,
   // Gates
   input wire [WIDTH-1:0] high_side_driver, input wire [WIDTH-1:0] low_side_driver,
   input wire reset_fast_driver, input wire weak_pullup
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Counts cycles of fast drive, a repetition would need the parameter
   integer fast_cnt;
   always @(posedge clk or posedge rst) begin
      if (rst)
         fast_cnt <= 0;
      else
         fast_cnt <= reset_fast_driver ? fast_cnt + 1 : 0;
   end
   property p_both; (high_side_driver & low_side_driver) == 0; endproperty
   a_both: assert property (p_both) else $error("both gates on");
   property p_fast_on; $fell(rst) |=> reset_fast_driver; endproperty
   a_fast_on: assert property (p_fast_on) else $error("fast drive late");
   property p_fast_len; $fell(reset_fast_driver) |-> fast_cnt == FAST_CYC; endproperty
   a_fast_len: assert property (p_fast_len) else $error("fast drive length");
   property p_pu_rst; $fell(rst) |-> weak_pullup; endproperty
   a_pu_rst: assert property (p_pu_rst) else $error("pull-up off");
   property p_pu_hold; weak_pullup && !(ce && wr && addr == 2'h1) |=> weak_pullup; endproperty
   a_pu_hold: assert property (p_pu_hold) else $error("pull-up lost");
   property p_pu_drop; ce && wr && addr == 2'h1 |=> !weak_pullup; endproperty
   a_pu_drop: assert property (p_pu_drop) else $error("pull-up kept");
   property p_idle; $fell(rst) |=> ((high_side_driver | low_side_driver) & 8'h7f) == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("pin driven");
   property p_rd_idle; ce && !rd |=> rdata == 0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
endmodule
bind bppc_port bppc_port_asserts #(.WIDTH(WIDTH), .FAST_CYC(FAST_CYC)) u_chk (.*);

// file: verification/testbench.sv
// Purpose: Port bench
// Assumes: Fast count cut to 3
// Notes: Bit 7 masked out of rd_chk and gates; rd7 and t_bit7 check it
`timescale 1ns/1ns
module testbench;
   reg clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, hrc = 1'h0;
   reg [1:0] addr = 2'h0;
   reg [7:0] wdata = 8'h00, pd = 8'h00, pv = 8'h00, xe = 8'h00, xv = 8'h12;
   wire [7:0] rdata, hs, ls, pin;
   wire rfd, wp;
   integer err_count = 0, compares = 0;
   always #10 clk = ~clk;
   always @(posedge clk) hrc <= ~hrc;
   bppc_port #(.FAST_CYC(3)) u_dut (.clk(clk), .rst(rst), .ce(1'h1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .periph_direction(pd), .periph_output_value(pv), .half_rate_clock_out(hrc), .pin_in(pin),
      .high_side_driver(hs), .low_side_driver(ls), .reset_fast_driver(rfd), .weak_pullup(wp));
   bppc_pins_model u_pins (.high_side_driver(hs), .low_side_driver(ls), .ext_en(xe), .ext_val(xv), .pin_in(pin));
   task chk(input [7:0] s, input [7:0] e);
      begin
         compares = compares + 1;
         if (s !== e) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: %h not %h", $time, s, e);
         end
      end
   endtask
   task wr_reg(input [1:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'h1;
         @(posedge clk);
         wr <= 1'h0;
      end
   endtask
   task rd_chk(input [1:0] a, input [7:0] e);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'h1;
         @(posedge clk);
         rd <= 1'h0;
         #1 chk(rdata & 8'h7f, e & 8'h7f);
      end
   endtask
   // Reads and judges bit 7 alone
   task rd7(input [1:0] a, input e);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'h1;
         @(posedge clk);
         rd <= 1'h0;
         #1 chk({7'h00, rdata[7]}, {7'h00, e});
      end
   endtask
   // Bit 7 clock mode and buffered data write
   task t_bit7;
      begin
         wr_reg(2'h2, 8'h80);
         rd7(2'h2, 1'h1);
         wr_reg(2'h1, 8'h80);
         wr_reg(2'h2, 8'h00);
         rd7(2'h2, 1'h1);
         #1 chk({7'h00, hs[7] ^ ls[7]}, 8'h01);
         wr_reg(2'h1, 8'h00);
         rd7(2'h2, 1'h0);
      end
   endtask
   // Expected gates for pins 0-6 from select, direction and data
   task gates(input [7:0] f, input [7:0] d, input [7:0] q);
      reg [7:0] dd, vv;
      begin
         dd = d | (f & pd);
         vv = (f & pv) | (~f & q);
         repeat (2) @(posedge clk);
         #1 chk(hs & 8'h7f, ~dd & vv & 8'h7f);
         chk(ls & 8'h7f, ~vv & 8'h7f);
      end
   endtask
   task t_reset;
      begin
         rd_chk(2'h0, 8'hff);
         rd_chk(2'h1, 8'h00);
         rd_chk(2'h2, 8'hff);
         chk({7'h00, wp}, 8'h01);
         chk({7'h00, hs[7] ^ ls[7]}, 8'h01);
         gates(8'h00, 8'hff, 8'hff);
      end
   endtask
   task t_io;
      begin
         wr_reg(2'h0, 8'h1f);
         wr_reg(2'h1, 8'h00);
         #1 chk({7'h00, wp}, 8'h00);
         wr_reg(2'h2, 8'hd3);
         gates(8'h00, 8'h1f, 8'hd3);
         xe <= 8'h7f;
         repeat (4) @(posedge clk);
         rd_chk(2'h3, 8'h52);
      end
   endtask
   task t_special;
      begin
         pd <= 8'h03;
         pv <= 8'h0a;
         wr_reg(2'h0, 8'h00);
         wr_reg(2'h1, 8'h0f);
         gates(8'h0f, 8'h00, 8'hd3);
         wr_reg(2'h2, 8'h2c);
         gates(8'h0f, 8'h00, 8'h2c);
         rd_chk(2'h2, 8'h2c);
      end
   endtask
   task print_verdict;
      begin
         $display("compares %0d, err_count %0d", compares, err_count);
         if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_reset;
      t_io;
      t_special;
      t_bit7;
      print_verdict;
   end
   // About 65 cycles of traffic, so 1000 is ample
   initial begin
      #20000;
      err_count = err_count + 1;
      print_verdict;
   end
endmodule
